// ---- verilog/fskw_pkg.sv ----
// Purpose: Shared constants and types for the FSK word serial interface.
// Assumes: ref_clk at 100 MHz; byte addresses on the register bus.
// Notes:   Long cycle counts are overridable parameters of the top module.
package fskw_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int BAUD_RATE = 1200;
   localparam int BIT_CYCLES_DEF = CLK_HZ / BAUD_RATE;
   localparam int HALF_BIT_CYCLES_DEF = CLK_HZ / (2 * BAUD_RATE);
   localparam int CD_HOLD_MS = 10;
   localparam int CD_HOLD_CYCLES_DEF = (CLK_HZ / 1000) * CD_HOLD_MS;
   localparam int CD_QUAL_US = 5000;
   localparam int CD_QUAL_CYCLES_DEF = (CLK_HZ / 1_000_000) * CD_QUAL_US;
   localparam int CNT_W = 20;
   localparam int DATA_BITS = 8;
   localparam int FIFO_DEPTH = 16;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_ERRORS = 4'h8;
   localparam int CTRL_BYTES = 3;
   localparam int ST_CARRIER = 0;
   localparam int ST_MODE = 1;
   localparam int ST_PDOWN = 2;
   localparam int ST_READY = 3;
   localparam int ST_LEVEL_LSB = 4;
   localparam int ST_LEFT_LSB = 12;
   localparam int ST_BYTE_LSB = 16;
   localparam int ERR_FRAME_LSB = 8;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b11,
      RX_STOP = 2'b10
   } fskw_rx_state_t;

   // Pin group of the three-wire interface and carrier indication.
   typedef struct packed {
      logic data;
      logic bit_clock_o;
      logic bit_clock_oe_n;
      logic word_ready_n_o;
      logic word_ready_n_oe_n;
      logic carrier_present_n_o;
      logic carrier_present_n_oe_n;
   } fskw_pins_t;
endpackage : fskw_pkg

// ---- verilog/fskw_sync.sv ----
// Purpose: Two-flop synchroniser for levels from outside ref_clk.
// Assumes: Inputs change slowly relative to ref_clk.
// Notes:   Only the second flop is visible to the rest of the design.
module fskw_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Levels
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   // Two stages; the first is read by the second only.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : fskw_sync

// ---- verilog/fskw_fifo.sv ----
// Purpose: Received-byte FIFO between the deframer and the output stage.
// Assumes: DEPTH is a power of two.
// Notes:   Full shows as in_ready low; the source must count the loss.
module fskw_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic flush,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic push;
   logic pop;

   // Pointers carry one extra bit so full and empty are distinct.
   assign level = wr_ptr - rd_ptr;
   assign in_ready = (level != (AW + 1)'(DEPTH));
   assign out_valid = (level != '0);
   assign out_data = mem[rd_ptr[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage needs no reset; only the pointers define content.
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   // Pointer update; flush empties the buffer at power-down.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else if (flush) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule : fskw_fifo

// ---- verilog/fskw_word_serial.sv ----
// Purpose: Digital output side of a 1200 baud FSK receiver: three-wire interface.
// Assumes: Demodulated bit and band activity come in asynchronously.
// Notes:   Register bus is Avalon-MM; every access answers after one wait cycle.
module fskw_word_serial #(
   parameter int BIT_CYCLES = fskw_pkg::BIT_CYCLES_DEF,
   parameter int HALF_BIT_CYCLES = fskw_pkg::HALF_BIT_CYCLES_DEF,
   parameter int CD_HOLD_CYCLES = fskw_pkg::CD_HOLD_CYCLES_DEF,
   parameter int CD_QUAL_CYCLES = fskw_pkg::CD_QUAL_CYCLES_DEF,
   parameter int FIFO_DEPTH = fskw_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Demodulator side, asynchronous
   input wire logic demod_bit,
   input wire logic band_activity,
   // Control pins, asynchronous
   input wire logic mode_select,
   input wire logic power_down_request,
   // Three-wire interface and carrier pin
   input wire logic serial_bit_clock_in,
   output fskw_pkg::fskw_pins_t pins,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   localparam int W = fskw_pkg::CNT_W;
   localparam int NB = fskw_pkg::DATA_BITS;
   localparam int LW = $clog2(FIFO_DEPTH) + 1;
   localparam logic [W-1:0] BIT_END = W'(BIT_CYCLES - 1);
   localparam logic [W-1:0] HALF_END = W'(HALF_BIT_CYCLES - 1);
   localparam logic [W-1:0] HOLD_END = W'(CD_HOLD_CYCLES - 1);
   localparam logic [3:0] LAST_BIT = 4'(NB - 1);
   localparam logic [3:0] FULL_BITS = 4'(NB);

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   logic [4:0] sync_q;
   logic demod_q;
   logic act_q;
   logic mode_q;
   logic pd_q;
   logic clk_in_q;
   logic demod_prev;
   logic clk_in_prev;

   fskw_sync #(.WIDTH(5)) u_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .d({demod_bit, band_activity, mode_select, power_down_request, serial_bit_clock_in}),
      .q(sync_q)
   );
   assign {demod_q, act_q, mode_q, pd_q, clk_in_q} = sync_q;

   // Edge history is kept on the synchronised copies only.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         demod_prev <= 1'b0; // Matches the synchroniser's reset level, so no false edge.
         clk_in_prev <= 1'b0;
      end else begin
         demod_prev <= demod_q;
         clk_in_prev <= clk_in_q;
      end
   end

   // ----------------------------------------------------------------
   // Carrier detection
   // ----------------------------------------------------------------
   logic carrier_on;
   logic [W-1:0] cd_cnt;
   logic [W-1:0] cd_qual;

   // Qualify on continuous activity, then hold through gaps shorter than the hold time.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         carrier_on <= 1'b0;
         cd_cnt <= '0;
      end else if (pd_q) begin
         carrier_on <= 1'b0;
         cd_cnt <= '0;
      end else if (!carrier_on) begin
         if (!act_q) begin
            cd_cnt <= '0;
         end else if (cd_cnt >= cd_qual) begin
            carrier_on <= 1'b1;
            cd_cnt <= '0;
         end else begin
            cd_cnt <= cd_cnt + 1'b1;
         end
      end else if (act_q) begin
         cd_cnt <= '0;
      end else if (cd_cnt == HOLD_END) begin
         carrier_on <= 1'b0;
         cd_cnt <= '0;
      end else begin
         cd_cnt <= cd_cnt + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Deframer and bit timing recovery
   // ----------------------------------------------------------------
   fskw_pkg::fskw_rx_state_t rx_state;
   logic [W-1:0] rx_cnt;
   logic [3:0] rx_bits;
   logic [NB-1:0] rx_shift;
   logic tick_half;
   logic tick_bit;
   logic sample;
   logic word_done;

   assign tick_half = (rx_cnt == HALF_END);
   assign tick_bit = (rx_cnt == BIT_END);
   assign sample = (rx_state == fskw_pkg::RX_DATA) && tick_bit;
   assign word_done = (rx_state == fskw_pkg::RX_STOP) && tick_bit;

   // The timer restarts at the start-bit centre, so each later wrap is a bit centre.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_state <= fskw_pkg::RX_IDLE;
         rx_cnt <= '0;
         rx_bits <= '0;
         rx_shift <= '0;
      end else if (pd_q || !carrier_on) begin
         rx_state <= fskw_pkg::RX_IDLE;
         rx_cnt <= '0;
         rx_bits <= '0;
      end else begin
         unique case (rx_state)
            fskw_pkg::RX_IDLE: begin
               rx_cnt <= '0;
               if (demod_prev && !demod_q) begin
                  rx_state <= fskw_pkg::RX_START;
               end
            end
            fskw_pkg::RX_START: begin
               rx_cnt <= rx_cnt + 1'b1;
               if (tick_half) begin
                  rx_cnt <= '0;
                  rx_bits <= '0;
                  // A start bit gone high by its centre was a glitch.
                  rx_state <= demod_q ? fskw_pkg::RX_IDLE : fskw_pkg::RX_DATA;
               end
            end
            fskw_pkg::RX_DATA: begin
               rx_cnt <= rx_cnt + 1'b1;
               if (tick_bit) begin
                  rx_cnt <= '0;
                  rx_shift <= {demod_q, rx_shift[NB-1:1]};
                  rx_bits <= rx_bits + 1'b1;
                  if (rx_bits == LAST_BIT) begin
                     rx_state <= fskw_pkg::RX_STOP;
                  end
               end
            end
            fskw_pkg::RX_STOP: begin
               rx_cnt <= rx_cnt + 1'b1;
               if (tick_bit) begin
                  rx_cnt <= '0;
                  rx_state <= fskw_pkg::RX_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Byte buffering and error counts
   // ----------------------------------------------------------------
   logic push_ok;
   logic fifo_in_ready;
   logic fifo_valid;
   logic fifo_pop;
   logic [NB-1:0] fifo_data;
   logic [LW-1:0] fifo_level;
   logic load;
   logic [3:0] bits_left;
   logic clk_rise;
   logic [7:0] overrun_cnt;
   logic [7:0] frame_cnt;
   logic [NB-1:0] last_byte;
   logic err_clear;

   assign push_ok = word_done && demod_q;
   assign clk_rise = mode_q && clk_in_q && !clk_in_prev;
   assign load = mode_q && carrier_on && !pd_q && (bits_left == '0) && fifo_valid;
   // Stream mode discards the buffered copy; byte mode stalls until the host reads.
   assign fifo_pop = load || !mode_q;

   fskw_fifo #(.WIDTH(NB), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .flush(pd_q),
      .in_valid(push_ok),
      .in_ready(fifo_in_ready),
      .in_data(rx_shift),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data),
      .level(fifo_level)
   );

   // Counters saturate; a new event in the clear cycle still counts.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         overrun_cnt <= '0;
         frame_cnt <= '0;
         last_byte <= '0;
      end else begin
         if (push_ok && fifo_in_ready) begin
            last_byte <= rx_shift;
         end
         if (push_ok && !fifo_in_ready) begin
            overrun_cnt <= (overrun_cnt == 8'hff) ? overrun_cnt : overrun_cnt + 1'b1;
         end else if (err_clear) begin
            overrun_cnt <= '0;
         end
         if (word_done && !demod_q) begin
            frame_cnt <= (frame_cnt == 8'hff) ? frame_cnt : frame_cnt + 1'b1;
         end else if (err_clear) begin
            frame_cnt <= '0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Output stage: data, bit clock and word ready
   // ----------------------------------------------------------------
   logic data_q;
   logic serial_bit_clock_q;
   logic [NB-1:0] out_sr;
   logic dr_n;
   logic [W-1:0] dr_cnt;
   logic dr_set;
   logic dr_early;

   // Byte-mode shift register; loads only when the previous byte is gone.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_sr <= '0;
         bits_left <= '0;
      end else if (pd_q) begin
         bits_left <= '0;
      end else if (load) begin
         out_sr <= fifo_data;
         bits_left <= FULL_BITS;
      end else if (clk_rise && bits_left != '0) begin
         out_sr <= out_sr >> 1;
         bits_left <= bits_left - 1'b1;
      end
   end

   // Data pin: raw stream gated by carrier, or the next buffered bit.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         data_q <= 1'b1;
      end else if (pd_q) begin
         data_q <= 1'b1;
      end else if (!mode_q) begin
         data_q <= carrier_on ? demod_q : 1'b1;
      end else if (clk_rise && bits_left != '0) begin
         data_q <= out_sr[0];
      end
   end

   // Stream-mode bit clock rises at each data centre and falls half a bit later.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         serial_bit_clock_q <= 1'b0;
      end else if (pd_q) begin
         serial_bit_clock_q <= 1'b1;
      end else if (sample) begin
         serial_bit_clock_q <= 1'b1;
      end else if (tick_half || rx_state == fskw_pkg::RX_IDLE) begin
         serial_bit_clock_q <= 1'b0;
      end
   end

   assign dr_set = (!mode_q && word_done) || load;
   assign dr_early = clk_rise && bits_left != '0;

   // Word-ready strobe; a new word restarts the half-bit timer.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dr_n <= 1'b1;
         dr_cnt <= '0;
      end else if (pd_q) begin
         dr_n <= 1'b1;
         dr_cnt <= '0;
      end else if (dr_set) begin
         dr_n <= 1'b0;
         dr_cnt <= '0;
      end else if (!dr_n) begin
         if (dr_early || dr_cnt == HALF_END) begin
            dr_n <= 1'b1;
         end
         dr_cnt <= dr_cnt + 1'b1;
      end
   end

   // Word ready and carrier pins are open drain in stream mode: only a low is ever driven.
   always_comb begin
      pins.data = data_q;
      pins.bit_clock_o = serial_bit_clock_q;
      pins.bit_clock_oe_n = mode_q;
      pins.word_ready_n_o = mode_q ? dr_n : 1'b0;
      pins.word_ready_n_oe_n = mode_q ? 1'b0 : dr_n;
      pins.carrier_present_n_o = mode_q ? !carrier_on : 1'b0;
      pins.carrier_present_n_oe_n = mode_q ? 1'b0 : !carrier_on;
   end

   // ----------------------------------------------------------------
   // Avalon-MM slave
   // ----------------------------------------------------------------
   logic ack_q;
   logic [31:0] ctrl;

   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign err_clear = avs_write && ack_q && avs_address == fskw_pkg::REG_ERRORS;
   assign cd_qual = ctrl[W-1:0];

   // One wait cycle gives every access a fixed two-edge latency.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
         avs_readdata <= '0;
         ctrl <= 32'(CD_QUAL_CYCLES);
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
         if (avs_read && !ack_q) begin
            avs_readdata <= '0;
            unique case (avs_address)
               fskw_pkg::REG_CTRL: avs_readdata <= {12'h000, ctrl[W-1:0]};
               fskw_pkg::REG_STATUS: begin
                  avs_readdata[fskw_pkg::ST_CARRIER] <= carrier_on;
                  avs_readdata[fskw_pkg::ST_MODE] <= mode_q;
                  avs_readdata[fskw_pkg::ST_PDOWN] <= pd_q;
                  avs_readdata[fskw_pkg::ST_READY] <= !dr_n;
                  avs_readdata[fskw_pkg::ST_LEVEL_LSB +: LW] <= fifo_level;
                  avs_readdata[fskw_pkg::ST_LEFT_LSB +: 4] <= bits_left;
                  avs_readdata[fskw_pkg::ST_BYTE_LSB +: NB] <= last_byte;
               end
               fskw_pkg::REG_ERRORS: begin
                  avs_readdata[7:0] <= overrun_cnt;
                  avs_readdata[fskw_pkg::ERR_FRAME_LSB +: 8] <= frame_cnt;
               end
               default: avs_readdata <= '0;
            endcase
         end
         if (avs_write && ack_q && avs_address == fskw_pkg::REG_CTRL) begin
            for (int i = 0; i < fskw_pkg::CTRL_BYTES; i++) begin
               if (avs_byteenable[i]) begin
                  ctrl[8*i +: 8] <= avs_writedata[8*i +: 8];
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence s_word_loaded;
      load ##1 (bits_left == FULL_BITS);
   endsequence
   sequence s_read_pulse;
      clk_rise && bits_left != '0;
   endsequence

   property p_load_strobe;
      load |-> s_word_loaded ##0 !dr_n;
   endproperty
   a_load_strobe: assert property (p_load_strobe) else $error("byte load did not strobe");

   property p_early_clear;
      (s_read_pulse ##0 !dr_n && !load) |=> dr_n;
   endproperty
   a_early_clear: assert property (p_early_clear) else $error("read pulse left ready low");

   property p_ignore_extra;
      (mode_q && clk_rise && bits_left == '0 && !pd_q) |=> $stable(data_q);
   endproperty
   a_ignore_extra: assert property (p_ignore_extra) else $error("extra bit clock moved data");

   property p_dr_length;
      !dr_n |-> dr_cnt <= HALF_END;
   endproperty
   a_dr_length: assert property (p_dr_length) else $error("ready low too long");

   property p_stream_clock;
      (sample && !pd_q && carrier_on) |=> serial_bit_clock_q ##1 serial_bit_clock_q;
   endproperty
   a_stream_clock: assert property (p_stream_clock) else $error("no bit clock at centre");

   property p_gate_data;
      (!carrier_on && !mode_q) |=> data_q;
   endproperty
   a_gate_data: assert property (p_gate_data) else $error("data passed without carrier");

   property p_cd_release;
      (carrier_on && !pd_q && !act_q && cd_cnt == HOLD_END) |=> !carrier_on;
   endproperty
   a_cd_release: assert property (p_cd_release) else $error("carrier held past hold time");

   property p_frame_start;
      (rx_state == fskw_pkg::RX_IDLE && demod_prev && !demod_q && carrier_on && !pd_q)
         |=> rx_state == fskw_pkg::RX_START;
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("falling edge missed");

   property p_power_down;
      pd_q |=> (rx_state == fskw_pkg::RX_IDLE) && dr_n && data_q && !carrier_on;
   endproperty
   a_power_down: assert property (p_power_down) else $error("power-down did not halt");

   property p_open_drain;
      !mode_q |-> (pins.word_ready_n_oe_n == dr_n) && !pins.word_ready_n_o;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("word ready drove high");
endmodule : fskw_word_serial

// ---- testbench/fskw_host_model.sv ----
// Purpose: Host model: shift register in stream mode, read clock in byte mode.
// Assumes: ref_clk at 100 MHz; read clock period 80 ns.
// Notes: Read clock stands low between reads.
module fskw_host_model (
   // Clock
   input wire logic ref_clk,
   // Lines from the block
   input wire fskw_pkg::fskw_pins_t pins,
   // Read clock to the block
   output logic rclk
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sr = 8'h00;
   int npulse = 0;
   initial rclk = 1'b0;
   // Shift in the data line on each driven bit clock rise.
   always @(posedge pins.bit_clock_o) begin
      if (!pins.bit_clock_oe_n) begin
         sr = {pins.data, sr[7:1]};
         npulse++;
      end
   end
   // Eight 40 ns pulses, 80 ns apart; a bit is taken late in the low phase, once it has settled.
   task automatic read_byte(output logic [7:0] b);
      @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
         rclk <= 1'b1;
         repeat (4) @(posedge ref_clk);
         rclk <= 1'b0;
         repeat (4) @(posedge ref_clk);
         b = {pins.data, b[7:1]};
      end
   endtask : read_byte
endmodule : fskw_host_model

// ---- testbench/tb_fskw_word_serial.sv ----
// Purpose: Self-checking bench of the word serial interface.
// Assumes: Shortened bit and carrier counts.
// Notes: Byte enables are held constant.
module tb_fskw_word_serial;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BIT = 40;
   logic ref_clk = 1'b0, rst_b = 1'b0, demod = 1'b1, band = 1'b0, mode = 1'b0, pd = 1'b0;
   logic rclk, rd = 1'b0, wr_en = 1'b0, waitreq, wr, cd, seen0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, q;
   logic [7:0] b;
   fskw_pkg::fskw_pins_t pins;
   int n_fail = 0, compares = 0, n, lowcnt = 0, lastlow = 0;
   assign wr = pins.word_ready_n_oe_n ? 1'b1 : pins.word_ready_n_o;
   assign cd = pins.carrier_present_n_oe_n ? 1'b1 : pins.carrier_present_n_o;
   fskw_word_serial #(.BIT_CYCLES(BIT), .HALF_BIT_CYCLES(20), .CD_HOLD_CYCLES(200),
      .CD_QUAL_CYCLES(30)) fskw_word_serial_inst (.ref_clk(ref_clk), .rst_b(rst_b),
      .demod_bit(demod), .band_activity(band), .mode_select(mode),
      .power_down_request(pd), .serial_bit_clock_in(rclk), .pins(pins),
      .avs_address(addr), .avs_read(rd), .avs_write(wr_en), .avs_writedata(wdata),
      .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(waitreq));
   fskw_host_model fskw_host_model_inst (.ref_clk(ref_clk), .pins(pins), .rclk(rclk));
   initial forever #5 ref_clk = ~ref_clk;
   // Length of each word ready pulse, and any low level on the data line.
   always @(posedge ref_clk) begin
      if (!wr) lowcnt <= lowcnt + 1;
      else if (lowcnt != 0) begin
         lastlow <= lowcnt;
         lowcnt <= 0;
      end
      if (!pins.data) seen0 <= 1'b1;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      rd <= !w;
      wr_en <= w;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
      while (waitreq) @(posedge ref_clk);
      q = rdata;
      rd <= 1'b0;
      wr_en <= 1'b0;
   endtask : bus
   task automatic send(input logic [7:0] v);
      logic [9:0] f;
      f = {1'b1, v, 1'b0};
      for (int i = 0; i < 10; i++) begin
         demod <= f[i];
         repeat (BIT) @(posedge ref_clk);
      end
   endtask : send
   task automatic summarize;
      if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   task automatic t_nocarrier;
      seen0 = 1'b0;
      send(8'h5a);
      chk(cd, 1'b1);
      chk(fskw_host_model_inst.npulse, 0);
      chk(seen0, 1'b0);
      bus(1'b0, 4'hc, 32'h0);
      chk(q, 32'h0);
   endtask : t_nocarrier
   task automatic t_stream;
      bus(1'b1, fskw_pkg::REG_CTRL, 32'h1e);
      bus(1'b0, fskw_pkg::REG_CTRL, 32'h0);
      chk(q[19:0], 20'h1e);
      band <= 1'b1;
      repeat (50) @(posedge ref_clk);
      chk(cd, 1'b0);
      chk(pins.word_ready_n_oe_n, 1'b1);
      send(8'ha5);
      repeat (BIT) @(posedge ref_clk);
      chk(fskw_host_model_inst.sr, 8'ha5);
      chk(fskw_host_model_inst.npulse, 8);
      chk(lastlow >= 20 && lastlow <= 21, 1'b1);
   endtask : t_stream
   task automatic t_byte;
      mode <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk({pins.word_ready_n_oe_n, wr}, 2'b01);
      fork
         send(8'hc3);
         begin
            n = 0;
            while (wr !== 1'b0 && n < 600) begin
               @(posedge ref_clk);
               n++;
            end
            chk(n < 600, 1'b1);
            fskw_host_model_inst.read_byte(b);
         end
      join
      chk(b, 8'hc3);
      chk(lastlow < 20, 1'b1);
      fskw_host_model_inst.read_byte(b);
      chk(b, 8'hff);
   endtask : t_byte
   // Power-down while the carrier is on must release the carrier, word ready and data lines at once.
   task automatic t_pdown;
      band <= 1'b1;
      repeat (50) @(posedge ref_clk);
      chk(cd, 1'b0);
      pd <= 1'b1;
      band <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk({cd, wr, pins.data}, 3'b111);
      pd <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask : t_pdown
   task automatic t_hold;
      band <= 1'b0;
      repeat (150) @(posedge ref_clk);
      chk(cd, 1'b0);
      repeat (80) @(posedge ref_clk);
      chk(cd, 1'b1);
   endtask : t_hold
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_nocarrier();
      t_stream();
      t_byte();
      t_hold();
      t_pdown();
      summarize();
   end
   // Cuts a hang short well past the roughly 1,700 cycles the run needs.
   initial begin
      #200us;
      n_fail++;
      summarize();
   end
endmodule : tb_fskw_word_serial
